// >>> hw/cfg_field_bit.v
`include "strap_consts.vh"

// One configuration bit: strap value at reset release, software afterwards
module cfg_field_bit #(
  parameter [0:0] RESET_VAL = 1'h0
) (
  input  wire clk_in,
  input  wire srst_in,
  input  wire ce_in,
  input  wire load_in,
  input  wire load_val_in,
  input  wire wr_in,
  input  wire wr_val_in,
  output wire q_out
);

  reg field_q;

  // ========================================================================
  // Storage
  // Capture wins over a write in the release cycle, so the strap is
  // always applied once before software can override it.
  always @(posedge clk_in) begin
    if (srst_in) begin
      field_q <= RESET_VAL;
    end else if (ce_in) begin
      if (load_in) begin
        field_q <= load_val_in;
      end else if (wr_in) begin
        field_q <= wr_val_in;
      end
    end
  end

  assign q_out = field_q;

endmodule

// >>> hw/strap_consts.vh
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// ==========================================================================
// Register map (byte addresses on the plain register port)
`define ADDR_CFG          8'h00
`define ADDR_STRAP        8'h04
`define ADDR_STATUS       8'h08
`define ADDR_BUS_SEL      8'h0C

// ==========================================================================
// Configuration field positions, one bit each
`define CFG_W             11
`define F_MDIX_DIS        0
`define F_P5_FC_EN        1
`define F_P5_BP_EN        2
`define F_DROP_EXC_COL    3
`define F_AGGR_BACKOFF    4
`define F_BIG_FRAME       5
`define F_P4_FORCE_FD     6
`define F_P4_FORCE_FC     7
`define F_HOST_FC_EN      8
`define F_HOST_HALF       9
`define F_HOST_10M        10

// Fields whose meaning is the inverse of the strap level.
// Equals the field values with every strap pulled down.
`define CFG_INV_MASK      11'h00A
`define CFG_RESET         11'h00A

// ==========================================================================
// Pins and status
`define PIN_W             10
`define STRAP_W           11
`define ST_DEFAULTS_ONLY  0
`define ST_BUS_SEL_LSB    1
`define ST_CAPTURED       3
`define BUS_SEL_W         2
`define BUS_SEL_RESET     2'h0

// ==========================================================================
// Largest frame lengths in bytes
`define MAX_LEN_STD       11'h5F2
`define MAX_LEN_BIG       11'h600

`endif

// >>> hw/strap_option_latch.v
`include "strap_consts.vh"

module strap_option_latch (
  input  wire                    clk_in,
  input  wire                    srst_in,
  input  wire                    ce_in,
  // Register port
  input  wire [7:0]              addr_in,
  input  wire [31:0]             wdata_in,
  input  wire                    wr_in,
  input  wire                    rd_in,
  output reg  [31:0]             rdata_out,
  // Strap-only input pin
  input  wire                    auto_crossover_disable_strap_in,
  // Shared strap pins, bit 0 upward: phy rx3,rx2,rx1,rx0,rxer,crs,col,
  // then host rx3,rx2,rx1
  input  wire [`PIN_W-1:0]       strap_pin_in,
  output reg  [`PIN_W-1:0]       strap_pin_drv_out,
  output wire [`PIN_W-1:0]       strap_pin_oe_out,
  output wire                    pulldown_en_out,
  input  wire [`PIN_W-1:0]       pin_func_data_in,
  // Presence of a configuration source
  input  wire                    cfg_mem_present_in,
  input  wire                    mcu_present_in,
  output reg                     defaults_only_out,
  output wire [`BUS_SEL_W-1:0]   serial_bus_select_out,
  // Configuration
  output wire                    auto_mdix_disable_out,
  output wire                    phy5_flowctl_en_out,
  output wire                    phy5_backpressure_en_out,
  output wire                    drop_excess_col_out,
  output wire                    aggr_backoff_en_out,
  output wire                    big_frame_en_out,
  output reg  [10:0]             max_frame_len_out,
  output wire                    port4_force_full_out,
  output wire                    port4_force_fc_out,
  output wire                    host_fc_en_out,
  output wire                    host_half_duplex_out,
  output wire                    host_10m_out
);

  // ========================================================================
  // Reset tracking
  reg                      in_reset_q;
  reg                      captured_q;
  reg  [`STRAP_W-1:0]      strap_q;
  reg  [`BUS_SEL_W-1:0]    bus_sel_q;
  wire                     capture;
  wire [`STRAP_W-1:0]      strap_now;
  wire [`CFG_W-1:0]        cfg_load;
  wire [`CFG_W-1:0]        cfg_q;
  wire                     wr_cfg;
  wire                     wr_bus_sel;

  // Both power-on and warm reset arrive as srst_in; each release
  // re-runs the capture.
  always @(posedge clk_in) begin
    if (srst_in) begin
      in_reset_q <= 1'h1;
    end else if (ce_in) begin
      in_reset_q <= 1'h0;
    end
  end

  assign capture = ce_in & ~srst_in & in_reset_q;

  // ========================================================================
  // Shared pin direction
  // Pins stay inputs through the capture cycle itself, so the level
  // sampled is the board resistor, never our own drive.
  assign strap_pin_oe_out = {`PIN_W{~in_reset_q}};
  assign pulldown_en_out  = in_reset_q;

  always @(posedge clk_in) begin
    if (srst_in) begin
      strap_pin_drv_out <= {`PIN_W{1'h0}};
    end else if (ce_in) begin
      strap_pin_drv_out <= pin_func_data_in;
    end
  end

  // ========================================================================
  // Strap capture
  assign strap_now = {strap_pin_in, auto_crossover_disable_strap_in};

  // Inverted fields make a pulled-down pin give the default value.
  assign cfg_load = strap_now ^ `CFG_INV_MASK;

  always @(posedge clk_in) begin
    if (srst_in) begin
      strap_q    <= {`STRAP_W{1'h0}};
      captured_q <= 1'h0;
    end else if (ce_in) begin
      if (capture) begin
        strap_q    <= strap_now;
        captured_q <= 1'h1;
      end
    end
  end

  // ========================================================================
  // Configuration fields
  assign wr_cfg     = wr_in & (addr_in == `ADDR_CFG);
  assign wr_bus_sel = wr_in & (addr_in == `ADDR_BUS_SEL);

  // Each field takes its own bit of the reset word
  localparam [`CFG_W-1:0] CFG_RST = `CFG_RESET;

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_MDIX_DIS])) u_mdix_dis (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_MDIX_DIS]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_MDIX_DIS]),
    .q_out       (cfg_q[`F_MDIX_DIS])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_P5_FC_EN])) u_p5_fc_en (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_P5_FC_EN]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_P5_FC_EN]),
    .q_out       (cfg_q[`F_P5_FC_EN])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_P5_BP_EN])) u_p5_bp_en (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_P5_BP_EN]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_P5_BP_EN]),
    .q_out       (cfg_q[`F_P5_BP_EN])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_DROP_EXC_COL])) u_drop_exc_col (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_DROP_EXC_COL]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_DROP_EXC_COL]),
    .q_out       (cfg_q[`F_DROP_EXC_COL])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_AGGR_BACKOFF])) u_aggr_backoff (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_AGGR_BACKOFF]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_AGGR_BACKOFF]),
    .q_out       (cfg_q[`F_AGGR_BACKOFF])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_BIG_FRAME])) u_big_frame (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_BIG_FRAME]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_BIG_FRAME]),
    .q_out       (cfg_q[`F_BIG_FRAME])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_P4_FORCE_FD])) u_p4_force_fd (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_P4_FORCE_FD]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_P4_FORCE_FD]),
    .q_out       (cfg_q[`F_P4_FORCE_FD])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_P4_FORCE_FC])) u_p4_force_fc (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_P4_FORCE_FC]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_P4_FORCE_FC]),
    .q_out       (cfg_q[`F_P4_FORCE_FC])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_HOST_FC_EN])) u_host_fc_en (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_HOST_FC_EN]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_HOST_FC_EN]),
    .q_out       (cfg_q[`F_HOST_FC_EN])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_HOST_HALF])) u_host_half (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_HOST_HALF]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_HOST_HALF]),
    .q_out       (cfg_q[`F_HOST_HALF])
  );

  cfg_field_bit #(.RESET_VAL(CFG_RST[`F_HOST_10M])) u_host_10m (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .load_in     (capture),
    .load_val_in (cfg_load[`F_HOST_10M]),
    .wr_in       (wr_cfg),
    .wr_val_in   (wdata_in[`F_HOST_10M]),
    .q_out       (cfg_q[`F_HOST_10M])
  );

  assign auto_mdix_disable_out    = cfg_q[`F_MDIX_DIS];
  assign phy5_flowctl_en_out      = cfg_q[`F_P5_FC_EN];
  assign phy5_backpressure_en_out = cfg_q[`F_P5_BP_EN];
  assign drop_excess_col_out      = cfg_q[`F_DROP_EXC_COL];
  assign aggr_backoff_en_out      = cfg_q[`F_AGGR_BACKOFF];
  assign big_frame_en_out         = cfg_q[`F_BIG_FRAME];
  assign port4_force_full_out     = cfg_q[`F_P4_FORCE_FD];
  assign port4_force_fc_out       = cfg_q[`F_P4_FORCE_FC];
  assign host_fc_en_out           = cfg_q[`F_HOST_FC_EN];
  assign host_half_duplex_out     = cfg_q[`F_HOST_HALF];
  assign host_10m_out             = cfg_q[`F_HOST_10M];

  // Frame length follows the field one cycle later; the limit is the
  // tagged length, untagged frames are checked at 4 bytes less downstream.
  always @(posedge clk_in) begin
    if (srst_in) begin
      max_frame_len_out <= `MAX_LEN_STD;
    end else if (ce_in) begin
      if (cfg_q[`F_BIG_FRAME]) begin
        max_frame_len_out <= `MAX_LEN_BIG;
      end else begin
        max_frame_len_out <= `MAX_LEN_STD;
      end
    end
  end

  // ========================================================================
  // Configuration source
  // Only a stand-alone switch relies on the straps alone; a memory or
  // controller may rewrite the fields through the register port.
  always @(posedge clk_in) begin
    if (srst_in) begin
      defaults_only_out <= 1'h0;
    end else if (ce_in) begin
      defaults_only_out <= ~cfg_mem_present_in &
                           ~mcu_present_in;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      bus_sel_q <= `BUS_SEL_RESET;
    end else if (ce_in) begin
      if (wr_bus_sel) begin
        bus_sel_q <= wdata_in[`BUS_SEL_W-1:0];
      end
    end
  end

  assign serial_bus_select_out = bus_sel_q;

  // ========================================================================
  // Register read
  always @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      if (!rd_in) begin
        rdata_out <= 32'h00000000;
      end else if (addr_in == `ADDR_CFG) begin
        rdata_out <= {{(32-`CFG_W){1'h0}}, cfg_q};
      end else if (addr_in == `ADDR_STRAP) begin
        rdata_out <= {{(32-`STRAP_W){1'h0}}, strap_q};
      end else if (addr_in == `ADDR_STATUS) begin
        rdata_out <= {28'h0000000, captured_q, bus_sel_q,
                      defaults_only_out};
      end else if (addr_in == `ADDR_BUS_SEL) begin
        rdata_out <= {30'h00000000, bus_sel_q};
      end else begin
        rdata_out <= 32'h00000000;
      end
    end
  end

endmodule

// >>> verification/strap_option_latch_monitor.sv
module strap_option_latch_monitor (
  input logic        clk_in, srst_in, ce_in, wr_in, rd_in,
  input logic [7:0]  addr_in,
  input logic [31:0] wdata_in, rdata_out,
  input logic        auto_crossover_disable_strap_in, pulldown_en_out,
  input logic [9:0]  strap_pin_in, strap_pin_drv_out, strap_pin_oe_out,
  input logic [9:0]  pin_func_data_in,
  input logic        cfg_mem_present_in, mcu_present_in, defaults_only_out,
  input logic [1:0]  serial_bus_select_out,
  input logic [10:0] max_frame_len_out,
  input logic        auto_mdix_disable_out, phy5_flowctl_en_out,
  input logic        phy5_backpressure_en_out, drop_excess_col_out,
  input logic        aggr_backoff_en_out, big_frame_en_out,
  input logic        port4_force_full_out, port4_force_fc_out,
  input logic        host_fc_en_out, host_half_duplex_out, host_10m_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [10:0] cfg = {host_10m_out, host_half_duplex_out, host_fc_en_out,
    port4_force_fc_out, port4_force_full_out, big_frame_en_out,
    aggr_backoff_en_out, drop_excess_col_out, phy5_backpressure_en_out,
    phy5_flowctl_en_out, auto_mdix_disable_out};
  wire [10:0] straps = {strap_pin_in, auto_crossover_disable_strap_in};
  wire [10:0] wlow   = wdata_in[10:0];
  wire        no_src = !cfg_mem_present_in && !mcu_present_in;
  wire        cfg_wr = wr_in && addr_in == 8'h00;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ==========
  // Capture edge and normal running
  // Keyed to the pull-down flag so a capture delayed by a low enable
  // is still seen as the capture edge
  sequence s_release;
    ce_in && pulldown_en_out;
  endsequence
  sequence s_run;
    ce_in && !pulldown_en_out;
  endsequence
  property p_pins;
    s_release |-> (strap_pin_oe_out == 10'h000 && pulldown_en_out)
      ##1 (strap_pin_oe_out == 10'h3FF && !pulldown_en_out);
  endproperty
  a_pins: assert property (p_pins) else $error("pin direction");
  property p_drv;
    s_run |=> strap_pin_drv_out == $past(pin_func_data_in);
  endproperty
  a_drv: assert property (p_drv) else $error("pin drive");
  property p_cap;
    s_release |=> cfg == ($past(straps) ^ 11'h00A);
  endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_hold;
    s_run ##0 !cfg_wr |=> $stable(cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("cfg moved");
  property p_wr;
    s_run ##0 cfg_wr |=> cfg == $past(wlow);
  endproperty
  a_wr: assert property (p_wr) else $error("cfg write");
  property p_rd;
    s_run ##0 (rd_in && addr_in == 8'h00) |=> rdata_out[10:0] == $past(cfg);
  endproperty
  a_rd: assert property (p_rd) else $error("cfg read");
  property p_len;
    ce_in |=> max_frame_len_out ==
      ($past(big_frame_en_out) ? 11'h600 : 11'h5F2);
  endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_dflt;
    ce_in |=> defaults_only_out == $past(no_src);
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults flag");
  property p_bus;
    s_release |-> serial_bus_select_out == 2'h0;
  endproperty
  a_bus: assert property (p_bus) else $error("bus select");
  property p_frz;
    !ce_in |=> $stable(cfg) && $stable(rdata_out) &&
      $stable(max_frame_len_out) && $stable(strap_pin_drv_out) &&
      $stable(strap_pin_oe_out) && $stable(serial_bus_select_out);
  endproperty
  a_frz: assert property (p_frz) else $error("enable low moved");
endmodule
bind strap_option_latch strap_option_latch_monitor mon (.*);

// >>> verification/strap_resistors.sv
// ==========
// Board strap resistors on the shared pins
module strap_resistors (
  input  logic [9:0] oe_in,
  input  logic [9:0] drv_in,
  input  logic [9:0] level_in,
  output logic [9:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin settles to its resistor level, never the last drive
  assign pin_out = (oe_in & drv_in) | (~oe_in & level_in);
endmodule

// >>> verification/test_strap_option_latch.sv
module test_strap_option_latch;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'h0, srst_in = 1'h1, ce_in = 1'h1, wr_in = 1'h0;
  logic        rd_in = 1'h0, auto_crossover_disable_strap_in = 1'h0;
  logic        cfg_mem_present_in = 1'h0, mcu_present_in = 1'h0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, v;
  logic [9:0]  strap_pin_in, strap_pin_drv_out, strap_pin_oe_out;
  logic [9:0]  pin_func_data_in = 10'h000, lvl = 10'h000;
  logic [10:0] max_frame_len_out, st, cfg;
  logic [1:0]  serial_bus_select_out;
  logic [15:0] seed = 16'h90AC;
  logic        pulldown_en_out, defaults_only_out, auto_mdix_disable_out;
  logic        phy5_flowctl_en_out, phy5_backpressure_en_out;
  logic        drop_excess_col_out, aggr_backoff_en_out, big_frame_en_out;
  logic        port4_force_full_out, port4_force_fc_out, host_fc_en_out;
  logic        host_half_duplex_out, host_10m_out;
  int          errors = 0, samples_checked = 0, i;
  assign cfg = {host_10m_out, host_half_duplex_out, host_fc_en_out,
    port4_force_fc_out, port4_force_full_out, big_frame_en_out,
    aggr_backoff_en_out, drop_excess_col_out, phy5_backpressure_en_out,
    phy5_flowctl_en_out, auto_mdix_disable_out};
  strap_option_latch dut (.*);
  strap_resistors board (.oe_in(strap_pin_oe_out), .drv_in(strap_pin_drv_out),
    .level_in(lvl), .pin_out(strap_pin_in));
  always #5 clk_in = ~clk_in;
  // ==========
  // Expectations and bus cycles
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Port 5 flow control and collision drop read inverted from their straps
  function automatic logic [10:0] exp_cfg(input logic [10:0] s);
    return s ^ 11'h00A;
  endfunction
  function automatic logic [10:0] exp_len(input logic big);
    return big ? 11'h600 : 11'h5F2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    #1 v = rdata_out;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    tally_and_finish;
  end
  // ==========
  // One warm reset per pass, with all-low and all-high corners first
  initial begin
    for (i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      st = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : seed[10:0];
      @(posedge clk_in);
      srst_in <= 1'h1;
      {lvl, auto_crossover_disable_strap_in} <= st;
      {cfg_mem_present_in, mcu_present_in} <= seed[15:14];
      pin_func_data_in <= seed[9:0];
      repeat (3) @(posedge clk_in);
      srst_in <= 1'h0;
      // Odd passes hold the enable low over the release edge
      ce_in <= !i[0];
      #1 chk({pulldown_en_out, strap_pin_oe_out}, 11'h400);
      @(posedge clk_in);
      ce_in <= 1'h1;
      repeat (1 + i[0]) @(posedge clk_in);
      #1 v = {21'h0, exp_cfg(st)};
      chk({pulldown_en_out, strap_pin_oe_out}, 11'h3FF);
      chk(strap_pin_drv_out, seed[9:0]);
      chk(cfg[3:0], v[3:0]);
      chk(cfg[8:4], v[8:4]);
      chk(cfg[10:9], v[10:9]);
      chk(max_frame_len_out, exp_len(st[5]));
      chk(defaults_only_out, !seed[15] && !seed[14]);
      bus(1'h0, 8'h0C, 32'h0);
      chk(v, 32'h0);
      bus(1'h0, 8'h04, 32'h0);
      chk(v, {21'h0, st});
      bus(1'h0, 8'h08, 32'h0);
      chk(v, {28'h0, 1'h1, 2'h0, !seed[15] && !seed[14]});
      // Late strap changes must not reach the configuration
      @(posedge clk_in);
      {lvl, auto_crossover_disable_strap_in} <= ~st;
      @(posedge clk_in);
      #1 chk(cfg, exp_cfg(st));
      seed = lfsr(seed);
      bus(1'h1, 8'h00, {21'h0, seed[10:0]});
      chk(cfg, seed[10:0]);
      bus(1'h1, 8'h0C, {30'h0, seed[12:11]});
      chk(serial_bus_select_out, seed[12:11]);
      bus(1'h0, 8'h0C, 32'h0);
      chk(v, {30'h0, seed[12:11]});
      bus(1'h1, 8'h10, 32'hFFFFFFFF);
      bus(1'h0, 8'h10, 32'h0);
      chk(v, 32'h0);
      bus(1'h0, 8'h00, 32'h0);
      chk(v, {21'h0, seed[10:0]});
      chk(max_frame_len_out, exp_len(seed[5]));
      // A write with the enable low must leave the fields alone
      @(posedge clk_in);
      ce_in <= 1'h0;
      bus(1'h1, 8'h00, {21'h0, ~seed[10:0]});
      @(posedge clk_in);
      ce_in <= 1'h1;
      #1 chk(cfg, seed[10:0]);
    end
    tally_and_finish;
  end
endmodule
